// >>> opm_pkg.sv
// Constants for the upper port pin multiplexer: register map, fields,
// reset values and input buffer kinds.
// Assumes a byte-wide register port on the system clock.
package opm_pkg;

  // ==========================================================
  // Register map
  localparam logic [3:0] OPM_REG_PIN    = 4'h0;
  localparam logic [3:0] OPM_REG_LATCH  = 4'h1;
  localparam logic [3:0] OPM_REG_DIR    = 4'h2;
  localparam logic [3:0] OPM_REG_MEMCTL = 4'h3;
  localparam logic [3:0] OPM_REG_PARCTL = 4'h4;

  // ==========================================================
  // Field positions
  localparam int OPM_EXT_BUS_DISABLE_BIT  = 7;
  localparam int OPM_PPMODE_BIT = 4;
  localparam int OPM_PIN_LO     = 5;

  // ==========================================================
  // Reset values: all pins inputs, latch clear, external bus off
  localparam logic [7:0] OPM_DIR_RST    = 8'hff;
  localparam logic [7:0] OPM_LATCH_RST  = 8'h00;
  localparam logic [7:0] OPM_MEMCTL_RST = 8'h80;
  localparam logic [7:0] OPM_PARCTL_RST = 8'h00;
  localparam logic [7:0] OPM_RD_UNMAP   = 8'h00;

  // ==========================================================
  // Input buffer kind presented on each upper pin
  typedef enum logic [1:0] {
    OPM_BUF_ST  = 2'b00,
    OPM_BUF_TTL = 2'b01,
    OPM_BUF_I2C = 2'b10,
    OPM_BUF_SMB = 2'b11
  } opm_buf_e;

endpackage

// >>> opm_sync.sv
// Two-stage synchroniser for pin levels.
// Assumes inputs are asynchronous to mclk_i.
module opm_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         mclk_i,
  input  wire logic         rst_i,
  // Levels
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta;

  // ==========================================================
  // First stage feeds only the second stage
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      meta   <= '0;
      sync_o <= '0;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end

endmodule

// >>> opm_pin_mux.sv
// Pin function multiplexer for pins 5 to 7 of the 8-bit port, plus
// the shared pin-value, latch, direction and mode registers.
// Assumes the memory interface, serial module and parallel port
// engines sit outside on mclk_i; pins are asynchronous.
//
// How it works
// - Direction one tristates pin, zero drives latch
// - Latch register reads back latch, not pins
// - Memory bus only while bus-disable bit clear
// - Parallel mode bit makes pins parallel port
// - Memory bus drives pin 5 above all
// - Memory bus drives pin 6 above all
// - Memory bus drives pin 7 above all
// - Memory read samples pins through TTL buffers
// - Parallel port read drives latch bits out
// - Parallel port write captured through TTL buffers
// - Pin 5 input feeds serial data in
// - Two-wire data output on pin 5 overrides when direction one
// - Two-wire data input uses module threshold choice
// - Pin 6 drives serial clock when direction zero
// - Pin 6 input feeds external serial clock
// - Two-wire clock output on pin 6 only when direction zero
// - Two-wire clock input uses module threshold choice
// - Pin 7 input feeds slave select, TTL
// - Don't-care functions ignore the direction bit
// - Memory bus functions only in large package
module opm_pin_mux
  import opm_pkg::*;
#(
  parameter bit HAS_EXT_BUS = 1'b1
) (
  // Clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  // Register port
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // Pins 5 to 7 and sensed levels of pins 0 to 4
  input  wire logic [2:0] pin_in_i,
  output logic      [2:0] pin_out_o,
  output logic      [2:0] pin_oe_o,
  output opm_buf_e        pin_buf_o [3],
  input  wire logic [4:0] pin_lo_i,
  // Shared settings for the lower pin logic
  output logic      [7:0] latch_o,
  output logic      [7:0] dir_o,
  output logic            ext_bus_on_o,
  output logic            par_mode_o,
  // Memory interface engine
  input  wire logic       mem_drive_i,
  input  wire logic       mem_read_i,
  input  wire logic [2:0] mem_ad_i,
  output logic      [2:0] mem_rdata_o,
  // Second serial module
  input  wire logic       ser_en_i,
  input  wire logic       ser_two_wire_i,
  input  wire logic       ser_smbus_i,
  input  wire logic       ser_clk_out_i,
  input  wire logic       ser_sda_out_i,
  output logic            ser_data_in_o,
  output logic            ser_clk_in_o,
  output logic            ser_ss_in_o,
  // Parallel slave port engine
  input  wire logic       par_rd_i,
  input  wire logic       par_wr_i,
  output logic      [2:0] par_wdata_o
);

  // ==========================================================
  // Storage and synchronised pins
  logic [7:0] latch;
  logic [7:0] dir;
  logic [7:0] memctl;
  logic [7:0] parctl;
  logic [7:0] pin_sync;
  logic [7:0] next_rdata;
  logic       bus_on;
  logic       par_on;
  logic [2:0] next_out;
  logic [2:0] next_oe;
  opm_buf_e   next_buf [3];

  opm_sync #(
    .W (8)
  ) u_sync (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .async_i ({pin_in_i, pin_lo_i}),
    .sync_o  (pin_sync)
  );

  // Threshold for two-wire inputs follows the module's own choice
  function automatic opm_buf_e tw_buf(input logic smb);
    return smb ? OPM_BUF_SMB : OPM_BUF_I2C;
  endfunction

  // Bus functions are absent in the small package build
  assign bus_on = HAS_EXT_BUS && !memctl[OPM_EXT_BUS_DISABLE_BIT];
  assign par_on = parctl[OPM_PPMODE_BIT];

  // ==========================================================
  // Register writes; pin-value writes land in the latch
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      latch <= OPM_LATCH_RST;
    end else if (wr_i && (addr_i == OPM_REG_PIN || addr_i == OPM_REG_LATCH)) begin
      latch <= wdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      dir <= OPM_DIR_RST;
    end else if (wr_i && addr_i == OPM_REG_DIR) begin
      dir <= wdata_i;
    end
  end

  // Mode registers
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      memctl <= OPM_MEMCTL_RST;
      parctl <= OPM_PARCTL_RST;
    end else if (wr_i) begin
      if (addr_i == OPM_REG_MEMCTL) begin
        memctl <= wdata_i;
      end
      if (addr_i == OPM_REG_PARCTL) begin
        parctl <= wdata_i;
      end
    end
  end

  // ==========================================================
  // Read data, valid the cycle after the strobe only
  always_comb begin
    case (addr_i)
      OPM_REG_PIN:    next_rdata = pin_sync;
      OPM_REG_LATCH:  next_rdata = latch;
      OPM_REG_DIR:    next_rdata = dir;
      OPM_REG_MEMCTL: next_rdata = memctl;
      OPM_REG_PARCTL: next_rdata = parctl;
      default:        next_rdata = OPM_RD_UNMAP;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_o <= OPM_RD_UNMAP;
    end else begin
      rdata_o <= rd_i ? next_rdata : OPM_RD_UNMAP;
    end
  end

  // ==========================================================
  // Pin owner selection; later assignments win, so the order
  // below is latch, parallel port, serial module, memory bus
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      next_out[i] = latch[OPM_PIN_LO+i];
      next_oe[i]  = !dir[OPM_PIN_LO+i];
      next_buf[i] = OPM_BUF_ST;
      if (par_on) begin
        next_buf[i] = OPM_BUF_TTL;
        next_oe[i]  = par_rd_i;
      end
    end
    if (ser_en_i) begin
      // Pin 5: data in, or two-wire data pulled low only
      if (dir[OPM_PIN_LO]) begin
        if (ser_two_wire_i) begin
          next_buf[0] = tw_buf(ser_smbus_i);
          next_out[0] = 1'b0;
          next_oe[0]  = !ser_sda_out_i;
        end else begin
          next_buf[0] = OPM_BUF_ST;
          next_oe[0]  = 1'b0;
        end
      end
      // Pin 6: clock out on direction zero, clock in on one
      if (!dir[OPM_PIN_LO+1]) begin
        next_out[1] = ser_clk_out_i;
        next_oe[1]  = 1'b1;
      end else begin
        next_buf[1] = ser_two_wire_i ? tw_buf(ser_smbus_i) : OPM_BUF_ST;
        next_oe[1]  = 1'b0;
      end
      // Pin 7: slave select only in SPI mode
      if (!ser_two_wire_i && dir[OPM_PIN_LO+2]) begin
        next_buf[2] = OPM_BUF_TTL;
        next_oe[2]  = 1'b0;
      end
    end
    if (bus_on) begin
      for (int i = 0; i < 3; i++) begin
        next_out[i] = mem_ad_i[i];
        next_oe[i]  = mem_drive_i;
        next_buf[i] = OPM_BUF_TTL;
      end
    end
  end

  // ==========================================================
  // Pin drivers registered so every output leaves a flop
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pin_out_o <= 3'h0;
      pin_oe_o  <= 3'h0;
      for (int i = 0; i < 3; i++) begin
        pin_buf_o[i] <= OPM_BUF_ST;
      end
    end else begin
      pin_out_o <= next_out;
      pin_oe_o  <= next_oe;
      for (int i = 0; i < 3; i++) begin
        pin_buf_o[i] <= next_buf[i];
      end
    end
  end

  // Settings mirrored for the lower pins
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      latch_o      <= OPM_LATCH_RST;
      dir_o        <= OPM_DIR_RST;
      ext_bus_on_o <= 1'b0;
      par_mode_o   <= 1'b0;
    end else begin
      latch_o      <= latch;
      dir_o        <= dir;
      ext_bus_on_o <= bus_on;
      par_mode_o   <= par_on;
    end
  end

  // ==========================================================
  // Captured inputs; memory reads and parallel writes ignore
  // direction bits, and both hold until the next capture
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      mem_rdata_o <= 3'h0;
    end else if (bus_on && mem_read_i) begin
      mem_rdata_o <= pin_sync[7:5];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      par_wdata_o <= 3'h0;
    end else if (par_on && par_wr_i && !bus_on) begin
      par_wdata_o <= pin_sync[7:5];
    end
  end

  // Serial inputs; the pin levels already passed two flops
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ser_data_in_o <= 1'b0;
      ser_clk_in_o  <= 1'b0;
      ser_ss_in_o   <= 1'b0;
    end else begin
      ser_data_in_o <= pin_sync[5];
      ser_clk_in_o  <= pin_sync[6];
      ser_ss_in_o   <= pin_sync[7];
    end
  end

  // ==========================================================
  // Checks on the registered outputs
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  bus_drives_pins_a: assert property (
    $past(bus_on) && $past(mem_drive_i) && !$past(rst_i)
      |-> pin_oe_o == 3'h7 && pin_out_o == $past(mem_ad_i))
    else $error("memory bus not driving pins");

  bus_ignores_dir_a: assert property (
    $past(bus_on) && !$past(mem_drive_i) && !$past(rst_i) |-> pin_oe_o == 3'h0)
    else $error("pins driven during bus read phase");

  bus_ttl_buf_a: assert property (
    $past(bus_on) && !$past(rst_i) |-> pin_buf_o[1] == OPM_BUF_TTL)
    else $error("bus input buffer not TTL");

  latch_plain_a: assert property (
    !$past(bus_on) && !$past(par_on) && !$past(ser_en_i) && !$past(rst_i)
      |-> pin_oe_o == ~$past(dir[7:5]) && pin_out_o == $past(latch[7:5]))
    else $error("plain port drive wrong");

  par_read_a: assert property (
    !$past(bus_on) && $past(par_on) && $past(par_rd_i) && !$past(ser_en_i)
      && !$past(rst_i) |-> pin_oe_o == 3'h7 && pin_out_o == $past(latch[7:5]))
    else $error("parallel read not driving latch");

  spi_clk_out_a: assert property (
    !bus_on && ser_en_i && !dir[6] ##1 !$past(rst_i)
      |-> pin_oe_o[1] && pin_out_o[1] == $past(ser_clk_out_i))
    else $error("serial clock not driven");

  tw_data_a: assert property (
    !bus_on && ser_en_i && ser_two_wire_i && dir[5] && !ser_sda_out_i
      |=> pin_oe_o[0] && !pin_out_o[0])
    else $error("two-wire data low not driven");

  tw_thresh_a: assert property (
    !bus_on && ser_en_i && ser_two_wire_i && dir[5]
      |=> pin_buf_o[0] == ($past(ser_smbus_i) ? OPM_BUF_SMB : OPM_BUF_I2C))
    else $error("two-wire threshold wrong");

  latch_read_a: assert property (
    rd_i && addr_i == OPM_REG_LATCH |=> rdata_o == $past(latch))
    else $error("latch read returns wrong value");

  pin_read_a: assert property (
    rd_i && addr_i == OPM_REG_PIN |=> rdata_o == $past(pin_sync))
    else $error("pin read returns wrong value");

  mem_capture_a: assert property (
    bus_on && mem_read_i |=> mem_rdata_o == $past(pin_sync[7:5]))
    else $error("memory read data not captured");

  // Serial input on pin 5 must stay undriven even during a parallel read
  ser_over_par_a: assert property (
    !$past(bus_on) && $past(ser_en_i) && !$past(ser_two_wire_i) && $past(dir[5])
      && !$past(rst_i) |-> !pin_oe_o[0])
    else $error("serial input pin driven by lower owner");

  ss_ttl_in_a: assert property (
    !bus_on && ser_en_i && !ser_two_wire_i && dir[7]
      |=> pin_buf_o[2] == OPM_BUF_TTL && !pin_oe_o[2])
    else $error("slave select input not TTL");

  // Bus disabled hands the pins back to plain port control
  bus_off_port_a: assert property (
    memctl[OPM_EXT_BUS_DISABLE_BIT] && !par_on && !ser_en_i
      |=> pin_oe_o == ~$past(dir[7:5]))
    else $error("pins not returned to port use");

  // Main scenarios
  bus_drive_c: cover property (bus_on && mem_drive_i ##1 pin_oe_o == 3'h7);
  par_read_c: cover property (par_on && par_rd_i && !bus_on);
  tw_mode_c: cover property (ser_en_i && ser_two_wire_i && !bus_on ##1 pin_oe_o[0]);

endmodule

// >>> opm_pad_model.sv
// Far-side pad model for pins 5 to 7: resolves device and external drive.
// Assumes the bench sets the external drive; released lines are pulled up.
module opm_pad_model (
  // Device side
  input  wire logic [2:0] dev_out_i,
  input  wire logic [2:0] dev_oe_i,
  // External master or peer
  input  wire logic [2:0] ext_oe_i,
  input  wire logic [2:0] ext_val_i,
  // Resolved pad levels
  output logic      [2:0] pad_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // Pad resolution; pull-up so a released line never reads stale
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (dev_oe_i[i])
        pad_o[i] = dev_out_i[i];
      else if (ext_oe_i[i])
        pad_o[i] = ext_val_i[i];
      else
        pad_o[i] = 1'b1;
    end
  end
endmodule

// >>> octal_port_upper_pin_mux_bench.sv
// Self-checking bench for the upper port pin multiplexer.
// Assumes a 100 MHz clock and the pad model on pins 5 to 7.
module octal_port_upper_pin_mux_bench;
  import opm_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic       mclk_i, rst_i, wr_i, rd_i;
  logic [3:0] addr_i;
  logic [7:0] wdata_i, rdata_o, latch_o, dir_o;
  logic [2:0] pin_in_i, pin_out_o, pin_oe_o, mem_ad_i, mem_rdata_o, par_wdata_o;
  logic [2:0] ext_oe, ext_val;
  logic [4:0] pin_lo_i;
  logic       ext_bus_on_o, par_mode_o, mem_drive_i, mem_read_i;
  logic       ser_en_i, ser_two_wire_i, ser_smbus_i, ser_clk_out_i, ser_sda_out_i;
  logic       ser_data_in_o, ser_clk_in_o, ser_ss_in_o, par_rd_i, par_wr_i;
  opm_buf_e   pin_buf_o [3];
  int         err_total, tests_run;

  // ==========================================================
  // Design and pads
  opm_pin_mux dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_in_i(pin_in_i),
    .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .pin_buf_o(pin_buf_o),
    .pin_lo_i(pin_lo_i), .latch_o(latch_o), .dir_o(dir_o), .ext_bus_on_o(ext_bus_on_o),
    .par_mode_o(par_mode_o), .mem_drive_i(mem_drive_i), .mem_read_i(mem_read_i),
    .mem_ad_i(mem_ad_i), .mem_rdata_o(mem_rdata_o), .ser_en_i(ser_en_i),
    .ser_two_wire_i(ser_two_wire_i), .ser_smbus_i(ser_smbus_i),
    .ser_clk_out_i(ser_clk_out_i), .ser_sda_out_i(ser_sda_out_i),
    .ser_data_in_o(ser_data_in_o), .ser_clk_in_o(ser_clk_in_o), .ser_ss_in_o(ser_ss_in_o),
    .par_rd_i(par_rd_i), .par_wr_i(par_wr_i), .par_wdata_o(par_wdata_o));
  opm_pad_model pad_u (.dev_out_i(pin_out_o), .dev_oe_i(pin_oe_o), .ext_oe_i(ext_oe),
    .ext_val_i(ext_val), .pad_o(pin_in_i));

  // ==========================================================
  // Clock, 10 ns period
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // ==========================================================
  // Helpers
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic reg_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, exp);
  endtask
  function automatic logic [7:0] bufs();
    return {2'h0, pin_buf_o[2], pin_buf_o[1], pin_buf_o[0]};
  endfunction

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    reg_chk(OPM_REG_LATCH, OPM_LATCH_RST);
    reg_chk(OPM_REG_DIR, OPM_DIR_RST);
    reg_chk(OPM_REG_MEMCTL, OPM_MEMCTL_RST);
    reg_chk(OPM_REG_PARCTL, OPM_PARCTL_RST);
    reg_chk(4'hf, OPM_RD_UNMAP);
    chk({5'h0, pin_oe_o}, 8'h00);
    $display("t_reset done");
  endtask

  task automatic t_port();
    reg_wr(OPM_REG_LATCH, 8'ha0);
    reg_wr(OPM_REG_DIR, 8'h1f);
    wt(2);
    chk({2'h0, pin_oe_o, pin_out_o}, 8'h3d);
    chk(latch_o, 8'ha0);
    chk(dir_o, 8'h1f);
    reg_chk(OPM_REG_PIN, 8'haa);
    reg_wr(OPM_REG_DIR, 8'hff);
    ext_oe <= 3'b111;
    ext_val <= 3'b010;
    wt(4);
    chk({5'h0, pin_oe_o}, 8'h00);
    chk(bufs(), {2'h0, OPM_BUF_ST, OPM_BUF_ST, OPM_BUF_ST});
    reg_chk(OPM_REG_LATCH, 8'ha0);
    reg_chk(OPM_REG_PIN, 8'h4a);
    reg_wr(OPM_REG_PIN, 8'h60);
    reg_chk(OPM_REG_LATCH, 8'h60);
    $display("t_port done");
  endtask

  // Bus on beats parallel read and latch, direction ignored
  task automatic t_mem();
    reg_wr(OPM_REG_PARCTL, 8'h10);
    reg_wr(OPM_REG_DIR, 8'h00);
    ext_oe <= 3'b000;
    reg_wr(OPM_REG_MEMCTL, 8'h00);
    par_rd_i <= 1'b1;
    mem_drive_i <= 1'b1;
    mem_ad_i <= 3'b101;
    wt(2);
    chk({2'h0, pin_oe_o, pin_out_o}, 8'h3d);
    chk(bufs(), {2'h0, OPM_BUF_TTL, OPM_BUF_TTL, OPM_BUF_TTL});
    chk({7'h0, ext_bus_on_o}, 8'h01);
    mem_drive_i <= 1'b0;
    mem_read_i <= 1'b1;
    ext_oe <= 3'b111;
    ext_val <= 3'b011;
    wt(5);
    chk({5'h0, mem_rdata_o}, 8'h03);
    mem_read_i <= 1'b0;
    ext_oe <= 3'b000;
    par_rd_i <= 1'b0;
    reg_wr(OPM_REG_MEMCTL, 8'h80);
    mem_drive_i <= 1'b1;
    wt(2);
    chk({2'h0, pin_oe_o, pin_out_o}, 8'h03);
    mem_drive_i <= 1'b0;
    $display("t_mem done");
  endtask

  task automatic t_par();
    reg_wr(OPM_REG_DIR, 8'hff);
    ext_oe <= 3'b111;
    ext_val <= 3'b110;
    // Pin levels need two flops before the strobe may capture them
    wt(3);
    par_wr_i <= 1'b1;
    @(posedge mclk_i);
    par_wr_i <= 1'b0;
    wt(4);
    chk({5'h0, par_wdata_o}, 8'h06);
    chk({7'h0, par_mode_o}, 8'h01);
    chk(bufs(), {2'h0, OPM_BUF_TTL, OPM_BUF_TTL, OPM_BUF_TTL});
    ext_oe <= 3'b000;
    par_rd_i <= 1'b1;
    wt(2);
    chk({2'h0, pin_oe_o, pin_out_o}, 8'h3b);
    $display("t_par done");
  endtask

  // Serial functions sit above the parallel read drive
  task automatic t_spi();
    ser_en_i <= 1'b1;
    ext_oe <= 3'b111;
    ext_val <= 3'b101;
    wt(5);
    chk({5'h0, ser_ss_in_o, ser_clk_in_o, ser_data_in_o}, 8'h05);
    chk(bufs(), {2'h0, OPM_BUF_TTL, OPM_BUF_ST, OPM_BUF_ST});
    ext_val <= 3'b010;
    wt(5);
    chk({5'h0, ser_ss_in_o, ser_clk_in_o, ser_data_in_o}, 8'h02);
    ext_oe <= 3'b101;
    reg_wr(OPM_REG_DIR, 8'hbf);
    wt(2);
    chk({4'h0, pin_oe_o, pin_out_o[1]}, 8'h04);
    $display("t_spi done");
  endtask

  task automatic t_i2c();
    ext_oe <= 3'b000;
    ser_two_wire_i <= 1'b1;
    ser_clk_out_i <= 1'b1;
    reg_wr(OPM_REG_DIR, 8'hff);
    wt(2);
    chk({4'h0, pin_oe_o[1:0], pin_out_o[1:0]}, 8'h06);
    chk({4'h0, pin_buf_o[1], pin_buf_o[0]}, {4'h0, OPM_BUF_I2C, OPM_BUF_I2C});
    ser_smbus_i <= 1'b1;
    ser_sda_out_i <= 1'b1;
    wt(2);
    chk({4'h0, pin_buf_o[1], pin_buf_o[0]}, {4'h0, OPM_BUF_SMB, OPM_BUF_SMB});
    chk({6'h0, pin_oe_o[1:0]}, 8'h00);
    reg_wr(OPM_REG_DIR, 8'hbf);
    wt(2);
    chk({6'h0, pin_oe_o[1], pin_out_o[1]}, 8'h03);
    $display("t_i2c done");
  endtask

  // ==========================================================
  // Verdict, reached from the main sequence or the watchdog
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Main sequence
  initial begin
    err_total = 0;
    tests_run = 0;
    {addr_i, wdata_i, wr_i, rd_i, mem_drive_i, mem_read_i, mem_ad_i} = '0;
    {ser_en_i, ser_two_wire_i, ser_smbus_i, ser_clk_out_i, ser_sda_out_i} = '0;
    {par_rd_i, par_wr_i, ext_oe, ext_val} = '0;
    pin_lo_i = 5'h0a;
    rst_i = 1'b1;
    repeat (12) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_reset();
    t_port();
    t_mem();
    t_par();
    t_spi();
    t_i2c();
    close_out();
  end

  // Watchdog: tests need about a hundred cycles, allow 50 us
  initial begin
    #50us;
    err_total++;
    close_out();
  end
endmodule
